//--- pkg/vgc_defines.svh
// offsets, field positions and reset values of the video configuration
`ifndef VGC_DEFINES_SVH
`define VGC_DEFINES_SVH
// ----------------------------------------------------------------------
// field layout of video_configuration
// ----------------------------------------------------------------------
`define VGC_MODE_HI      30
`define VGC_MODE_LO      29
`define VGC_COLOR_BIT    28
`define VGC_BCHROMA_BIT  27
`define VGC_BBCHROMA_BIT 26
`define VGC_AURAL_HI     25
`define VGC_AURAL_LO     23
`define VGC_GROUP_HI     11
`define VGC_GROUP_LO     9
`define VGC_MASK_HI      7
`define VGC_MASK_LO      0
// ----------------------------------------------------------------------
// partial-field write windows
// ----------------------------------------------------------------------
`define VGC_INSTR_HI     31
`define VGC_INSTR_LO     23
`define VGC_DEST_HI      17
`define VGC_DEST_LO      9
`define VGC_SRC_HI       8
`define VGC_SRC_LO       0
// ----------------------------------------------------------------------
// reset values and group decode
// ----------------------------------------------------------------------
`define VGC_CFG_RESET    32'h0000_0000
`define VGC_GROUP_COUNT  3'h4
`define VGC_GROUP_PINS   8
`endif

//--- pkg/vgc_pkg.sv
// types shared by the video configuration block
package vgc_pkg;
  // output mode, order matches the two-bit mode field
  typedef enum logic [1:0] {
    VGC_OFF,
    VGC_VGA,
    VGC_COMP_BCAST_HI,
    VGC_COMP_BASE_HI
  } vgc_mode_t;

  // kind of write: whole word or one instruction field
  typedef enum logic [1:0] {
    VGC_WR_FULL,
    VGC_WR_INSTR,
    VGC_WR_DEST,
    VGC_WR_SRC
  } vgc_wr_kind_t;
endpackage

//--- rtl/vgc_config.sv
// per-core video generator configuration register and output steering
// Contract
// - configuration register reads back the held value one cycle behind
// - mode 00 disables video, no pins driven
// - mode 01 drives 8-bit parallel data on the masked pins of the chosen group
// - mode 10: broadcast on upper nibble, baseband on lower
// - mode 11: baseband on upper nibble, broadcast on lower
// - colour bit 0: 1-bit pixels, only colours 0 and 1
// - colour bit 1: 2-bit pixels, colours 0 to 3
// - broadcast chroma enable bit gates colour on broadcast signal
// - baseband chroma enable bit gates colour on baseband signal
// - three-bit field picks which core clock feeds aural carrier
// - upper, destination and source fields writable separately
// - group 0..3 picks pins 7..0 up to 31..24; 4..7 reserved
// - eight-bit mask gates which pins of the group carry video
`timescale 1ns/100ps
`include "vgc_defines.svh"
module vgc_config #(
  parameter int CORES = 8
) (
  input  wire logic                CLK,
  input  wire logic                NRST,
  input  wire logic                CFG_WR,
  input  wire vgc_pkg::vgc_wr_kind_t CFG_WR_KIND,
  input  wire logic [31:0]         CFG_WDATA,
  output logic      [31:0]         CFG_RDATA,
  input  wire logic [7:0]          VGA_BYTE,
  input  wire logic [3:0]          BCAST_NIB,
  input  wire logic [3:0]          BASE_NIB,
  input  wire logic [1:0]          PIXEL_CODE,
  input  wire logic [CORES-1:0]    CORE_SYNTH_CLOCK,
  output logic      [31:0]         PIN_OUT,
  output logic      [31:0]         PIN_OE,
  output logic      [1:0]          COLOR_INDEX,
  output logic      [5:0]          PIXELS_PER_WORD,
  output logic                     BCAST_CHROMA_ON,
  output logic                     BASE_CHROMA_ON,
  output logic                     AURAL_CARRIER
);
  logic [31:0]      cfg;
  logic [31:0]      next_cfg;
  logic [CORES-1:0] synth_meta;
  logic [CORES-1:0] synth_sync;
  logic [31:0]      map_out;
  logic [31:0]      map_oe;
  vgc_pkg::vgc_mode_t mode;
  logic [2:0]       aural_sel;

  // ----------------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------------
  // only named fields are decoded, so bits 31, 22..12 and 8 are inert
  assign mode      =
    vgc_pkg::vgc_mode_t'(cfg[`VGC_MODE_HI:`VGC_MODE_LO]);
  assign aural_sel = cfg[`VGC_AURAL_HI:`VGC_AURAL_LO];

  // ----------------------------------------------------------------------
  // register write path
  // ----------------------------------------------------------------------
  // partial writes merge one instruction field into the held word
  always_comb begin
    next_cfg = cfg;
    case (CFG_WR_KIND)
      vgc_pkg::VGC_WR_FULL: begin
        next_cfg = CFG_WDATA;
      end
      vgc_pkg::VGC_WR_INSTR: begin
        next_cfg[`VGC_INSTR_HI:`VGC_INSTR_LO] =
          CFG_WDATA[`VGC_INSTR_HI:`VGC_INSTR_LO];
      end
      vgc_pkg::VGC_WR_DEST: begin
        next_cfg[`VGC_DEST_HI:`VGC_DEST_LO] =
          CFG_WDATA[`VGC_DEST_HI:`VGC_DEST_LO];
      end
      vgc_pkg::VGC_WR_SRC: begin
        next_cfg[`VGC_SRC_HI:`VGC_SRC_LO] =
          CFG_WDATA[`VGC_SRC_HI:`VGC_SRC_LO];
      end
      default: begin
        next_cfg = cfg;
      end
    endcase
  end

  // held configuration word
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      cfg <= `VGC_CFG_RESET;
    end else if (CFG_WR) begin
      cfg <= next_cfg;
    end
  end

  // read back the whole held word, one cycle behind
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      CFG_RDATA <= `VGC_CFG_RESET;
    end else begin
      CFG_RDATA <= cfg;
    end
  end

  // ----------------------------------------------------------------------
  // pin steering
  // ----------------------------------------------------------------------
  vgc_pin_map u_map (
    .mode      (mode),
    .group     (cfg[`VGC_GROUP_HI:`VGC_GROUP_LO]),
    .mask      (cfg[`VGC_MASK_HI:`VGC_MASK_LO]),
    .vga_byte  (VGA_BYTE),
    .bcast_nib (BCAST_NIB),
    .base_nib  (BASE_NIB),
    .pin_out   (map_out),
    .pin_oe    (map_oe)
  );

  // pins registered so nothing glitches when the config changes
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      PIN_OUT <= 32'h0000_0000;
      PIN_OE  <= 32'h0000_0000;
    end else begin
      PIN_OUT <= map_out;
      PIN_OE  <= map_oe;
    end
  end

  // ----------------------------------------------------------------------
  // pixel format and chroma
  // ----------------------------------------------------------------------
  // two-colour mode forces the upper colour bit low
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      COLOR_INDEX     <= 2'h0;
      PIXELS_PER_WORD <= 6'h20;
    end else if (cfg[`VGC_COLOR_BIT]) begin
      COLOR_INDEX     <= PIXEL_CODE;
      PIXELS_PER_WORD <= 6'h10;
    end else begin
      COLOR_INDEX     <= {1'b0, PIXEL_CODE[0]};
      PIXELS_PER_WORD <= 6'h20;
    end
  end

  // chroma enables only matter while a composite mode is chosen
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      BCAST_CHROMA_ON <= 1'b0;
      BASE_CHROMA_ON  <= 1'b0;
    end else begin
      BCAST_CHROMA_ON <= cfg[`VGC_BCHROMA_BIT] & mode[1];
      BASE_CHROMA_ON  <= cfg[`VGC_BBCHROMA_BIT] & mode[1];
    end
  end

  // ----------------------------------------------------------------------
  // aural sub-carrier source
  // ----------------------------------------------------------------------
  // foreign core clocks are sampled, so the carrier is only valid
  // well below half the 40 MHz system clock
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      synth_meta <= '0;
      synth_sync <= '0;
    end else begin
      synth_meta <= CORE_SYNTH_CLOCK;
      synth_sync <= synth_meta;
    end
  end

  // carrier muxed from the synchronised copies
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      AURAL_CARRIER <= 1'b0;
    end else begin
      AURAL_CARRIER <= synth_sync[aural_sel];
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  a_full_readback: assert property (
    CFG_WR && CFG_WR_KIND == vgc_pkg::VGC_WR_FULL
      |-> ##2 CFG_RDATA == $past(CFG_WDATA, 2))
    else $error("readback differs from written word");

  a_src_keeps_upper: assert property (
    CFG_WR && CFG_WR_KIND == vgc_pkg::VGC_WR_SRC
      |=> cfg[31:9] == $past(cfg[31:9]) && cfg[8:0] == $past(CFG_WDATA[8:0]))
    else $error("source-field write disturbed other bits");

  a_off_no_pins: assert property (
    mode == vgc_pkg::VGC_OFF |=> PIN_OE == 32'h0000_0000)
    else $error("pins driven while disabled");

  a_vga_byte: assert property (
    mode == vgc_pkg::VGC_VGA && cfg[11:9] == 3'h0 && cfg[7:0] == 8'hff
      |=> PIN_OUT[7:0] == $past(VGA_BYTE) && PIN_OE[7:0] == 8'hff)
    else $error("parallel byte not on group pins");

  a_comp_bcast_hi: assert property (
    mode == vgc_pkg::VGC_COMP_BCAST_HI && cfg[11:9] == 3'h1
      && cfg[7:0] == 8'hff
      |=> PIN_OUT[15:8] == {$past(BCAST_NIB), $past(BASE_NIB)})
    else $error("composite mode 1 nibble order wrong");

  a_comp_base_hi: assert property (
    mode == vgc_pkg::VGC_COMP_BASE_HI && cfg[11:9] == 3'h3
      && cfg[7:0] == 8'hff
      |=> PIN_OUT[31:24] == {$past(BASE_NIB), $past(BCAST_NIB)})
    else $error("composite mode 2 nibble order wrong");

  a_mask_gates_pins: assert property (
    mode != vgc_pkg::VGC_OFF && cfg[11:9] == 3'h2
      |=> PIN_OE[23:16] == $past(cfg[7:0]) && PIN_OE[15:0] == 16'h0000)
    else $error("pin enables do not follow mask");

  a_reserved_group: assert property (
    cfg[11] |=> PIN_OE == 32'h0000_0000)
    else $error("reserved group drove pins");

  a_two_colour: assert property (
    !cfg[`VGC_COLOR_BIT] |=> !COLOR_INDEX[1] && PIXELS_PER_WORD == 6'h20)
    else $error("colour above 1 in two-colour mode");

  a_four_colour: assert property (
    cfg[`VGC_COLOR_BIT] |=> COLOR_INDEX == $past(PIXEL_CODE)
      && PIXELS_PER_WORD == 6'h10)
    else $error("four-colour pixel not passed");

  a_chroma_gate: assert property (
    mode[1] |=> BCAST_CHROMA_ON == $past(cfg[27])
      && BASE_CHROMA_ON == $past(cfg[26]))
    else $error("chroma enable does not follow bit");

  // judged against the raw core clocks three edges back, so a broken
  // synchroniser or a wrong mux index both show up here
  a_aural_source: assert property (
    1'b1 |-> AURAL_CARRIER
      == 1'($past(CORE_SYNTH_CLOCK, 3) >> $past(aural_sel)))
    else $error("aural carrier from wrong core");

  c_vga_mode: cover property (mode == vgc_pkg::VGC_VGA && PIN_OE != 0);
  c_comp_mode: cover property (mode == vgc_pkg::VGC_COMP_BCAST_HI
                               && BCAST_CHROMA_ON);
  c_partial_write: cover property (CFG_WR
                                   && CFG_WR_KIND == vgc_pkg::VGC_WR_DEST);
  c_aural_toggle: cover property (AURAL_CARRIER ##1 !AURAL_CARRIER);
endmodule

//--- rtl/vgc_pin_map.sv
// combinational mapping of video nibbles onto a masked 8-pin group
`timescale 1ns/100ps
`include "vgc_defines.svh"
module vgc_pin_map (
  input  wire vgc_pkg::vgc_mode_t mode,
  input  wire logic [2:0]         group,
  input  wire logic [7:0]         mask,
  input  wire logic [7:0]         vga_byte,
  input  wire logic [3:0]         bcast_nib,
  input  wire logic [3:0]         base_nib,
  output logic      [31:0]        pin_out,
  output logic      [31:0]        pin_oe
);
  logic [7:0] grp_data;
  logic [7:0] grp_en;

  // ----------------------------------------------------------------------
  // byte built per mode, then placed in the chosen group
  // ----------------------------------------------------------------------
  always_comb begin
    grp_data = 8'h00;
    grp_en   = mask;
    case (mode)
      vgc_pkg::VGC_OFF: begin
        grp_en = 8'h00;
      end
      vgc_pkg::VGC_VGA: begin
        grp_data = vga_byte;
      end
      vgc_pkg::VGC_COMP_BCAST_HI: begin
        grp_data = {bcast_nib, base_nib};
      end
      vgc_pkg::VGC_COMP_BASE_HI: begin
        grp_data = {base_nib, bcast_nib};
      end
      default: begin
        grp_en = 8'h00;
      end
    endcase
    pin_out = 32'h0000_0000;
    pin_oe  = 32'h0000_0000;
    // reserved groups drive nothing at all
    if (group < `VGC_GROUP_COUNT) begin
      pin_out[group[1:0]*`VGC_GROUP_PINS +: 8] = grp_data & grp_en;
      pin_oe[group[1:0]*`VGC_GROUP_PINS +: 8]  = grp_en;
    end
  end
endmodule

//--- test/vgc_display_model.sv
// display model that watches the video pins of one core
`timescale 1ns/100ps
module vgc_display_model (
  input  wire logic        clk,
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  output logic      [31:0] seen
);
  logic [31:0] last;
  // ----------------------------------------------------------------------
  // pin level as the monitor sees it
  // ----------------------------------------------------------------------
  // released pins float: show the inverse of their last level, not a guess
  always_comb seen = (pin_out & pin_oe) | (~last & ~pin_oe);
  always_ff @(posedge clk) last <= seen;
endmodule

//--- test/video_generator_config_tb_top.sv
// self-checking bench of the video configuration register
`timescale 1ns/100ps
module video_generator_config_tb_top;
  logic                  clk = 0;
  logic                  nrst = 0;
  logic                  wr = 0;
  vgc_pkg::vgc_wr_kind_t kind = vgc_pkg::VGC_WR_FULL;
  logic [31:0]           wdata = 32'h0000_0000;
  logic [7:0]            vga = 8'hA5;
  logic [3:0]            bc = 4'h3;
  logic [3:0]            bb = 4'hC;
  logic [1:0]            pcode = 2'h3;
  logic [7:0]            synth = 8'h00;
  logic [31:0]           rdata, pout, poe, seen;
  logic [1:0]            cidx;
  logic [5:0]            ppw;
  logic                  bch, bbch, aural;
  int                    fail_count = 0;
  int                    comparisons = 0;

  // ----------------------------------------------------------------------
  // clock, device and display
  // ----------------------------------------------------------------------
  always #12.5 clk = ~clk;
  vgc_config i_dut (.CLK(clk), .NRST(nrst), .CFG_WR(wr), .CFG_WR_KIND(kind),
    .CFG_WDATA(wdata), .CFG_RDATA(rdata), .VGA_BYTE(vga), .BCAST_NIB(bc),
    .BASE_NIB(bb), .PIXEL_CODE(pcode), .CORE_SYNTH_CLOCK(synth),
    .PIN_OUT(pout), .PIN_OE(poe), .COLOR_INDEX(cidx),
    .PIXELS_PER_WORD(ppw), .BCAST_CHROMA_ON(bch), .BASE_CHROMA_ON(bbch),
    .AURAL_CARRIER(aural));
  vgc_display_model i_disp (.clk(clk), .pin_out(pout), .pin_oe(poe),
    .seen(seen));

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one-cycle strobe; derived outputs settle one edge after the take
  task automatic cfg_write(input vgc_pkg::vgc_wr_kind_t k,
                           input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    kind <= k;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  function automatic logic [31:0] cfg_word(input int m, input int g,
                                           input int msk);
    return (32'(m) << 29) | (32'(g) << 9) | 32'(msk);
  endfunction

  task automatic end_of_test;
    $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    chk(rdata, 32'h0000_0000);
    chk(poe, 32'h0000_0000);
    chk(32'(ppw), 32'h0000_0020);
  endtask

  // every mode on every group, full mask, then reserved groups
  task automatic t_modes;
    logic [7:0] b;
    for (int m = 0; m < 4; m++) begin
      for (int g = 0; g < 8; g++) begin
        cfg_write(vgc_pkg::VGC_WR_FULL, cfg_word(m, g, 8'hFF));
        b = (m == 1) ? vga : (m == 2) ? {bc, bb} : {bb, bc};
        if (m == 0 || g > 3) begin
          chk(poe, 32'h0000_0000);
          chk(pout, 32'h0000_0000);
        end else begin
          chk(poe, 32'h0000_00FF << (g * 8));
          chk(pout, 32'(b) << (g * 8));
          chk(seen & poe, 32'(b) << (g * 8));
        end
      end
    end
  endtask

  // half masks pick one nibble; video changes follow one cycle later
  task automatic t_mask;
    cfg_write(vgc_pkg::VGC_WR_FULL, cfg_word(2, 3, 8'h0F));
    chk(poe, 32'h0F00_0000);
    chk(pout, 32'h0C00_0000);
    cfg_write(vgc_pkg::VGC_WR_FULL, cfg_word(3, 0, 8'hF0));
    chk(poe, 32'h0000_00F0);
    chk(pout, 32'h0000_00C0);
    @(posedge clk);
    bb <= 4'h6;
    @(posedge clk);
    @(posedge clk);
    #1;
    chk(pout, 32'h0000_0060);
  endtask

  task automatic t_colour;
    cfg_write(vgc_pkg::VGC_WR_FULL, cfg_word(1, 0, 8'hFF));
    chk(32'(cidx), 32'h0000_0001);
    chk(32'(ppw), 32'h0000_0020);
    cfg_write(vgc_pkg::VGC_WR_FULL, cfg_word(1, 0, 8'hFF) | 32'h1000_0000);
    chk(32'(cidx), 32'h0000_0003);
    chk(32'(ppw), 32'h0000_0010);
  endtask

  task automatic t_chroma;
    cfg_write(vgc_pkg::VGC_WR_FULL, cfg_word(2, 1, 8'hFF) | 32'h0800_0000);
    chk(32'({bch, bbch}), 32'h0000_0002);
    cfg_write(vgc_pkg::VGC_WR_FULL, cfg_word(3, 1, 8'hFF) | 32'h0400_0000);
    chk(32'({bch, bbch}), 32'h0000_0001);
    // parallel mode carries no chroma even with both bits set
    cfg_write(vgc_pkg::VGC_WR_FULL, cfg_word(1, 1, 8'hFF) | 32'h0C00_0000);
    chk(32'({bch, bbch}), 32'h0000_0000);
  endtask

  // each core clock in turn, the others driven opposite
  task automatic t_aural;
    for (int k = 0; k < 8; k++) begin
      cfg_write(vgc_pkg::VGC_WR_FULL, 32'(k) << 23);
      @(posedge clk);
      synth <= ~(8'h01 << k);
      repeat (4) @(posedge clk);
      #1;
      chk(32'(aural), 32'h0000_0000);
      @(posedge clk);
      synth <= 8'h01 << k;
      repeat (4) @(posedge clk);
      #1;
      chk(32'(aural), 32'h0000_0001);
    end
    @(posedge clk);
    synth <= 8'h00;
  endtask

  // partial kinds merge; unused bits stored yet decode nothing
  task automatic t_fields;
    cfg_write(vgc_pkg::VGC_WR_FULL, 32'h8000_0100);
    chk(rdata, 32'h8000_0100);
    chk(poe, 32'h0000_0000);
    cfg_write(vgc_pkg::VGC_WR_FULL, 32'h0000_0000);
    cfg_write(vgc_pkg::VGC_WR_INSTR, 32'hFFFF_FFFF);
    chk(rdata, 32'hFF80_0000);
    cfg_write(vgc_pkg::VGC_WR_DEST, 32'hFFFF_FFFF);
    chk(rdata, 32'hFF83_FE00);
    cfg_write(vgc_pkg::VGC_WR_SRC, 32'hFFFF_FFFF);
    chk(rdata, 32'hFF83_FFFF);
    cfg_write(vgc_pkg::VGC_WR_DEST, 32'h0000_0400);
    chk(poe, 32'h00FF_0000);
  endtask

  // ----------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_modes();
    t_mask();
    t_colour();
    t_chroma();
    t_aural();
    t_fields();
    end_of_test();
  end

  // the sequence needs about 254 cycles; allow over eleven times that
  initial begin
    #75000;
    fail_count++;
    end_of_test();
  end
endmodule
